// ===== inc/ddc_channel_defs.vh
`ifndef DDC_CHANNEL_DEFS_VH
`define DDC_CHANNEL_DEFS_VH
// Channel address map.
`define ADDR_W          10
`define A_COEFFICIENT_MEMORY_LAST     10'h07F
`define A_SLEEP         10'h080
`define A_SOFT_SYNC     10'h081
`define A_PIN_SYNC      10'h082
`define A_START_HOLD    10'h083
`define A_FREQ_HOLD     10'h084
`define A_FREQ_LO       10'h085
`define A_FREQ_HI       10'h086
`define A_PHASE_OFS     10'h087
`define A_OSC_CTRL      10'h088
`define A_RS_DEC        10'h090
`define A_RS_INT        10'h091
`define A_RS_SCALE      10'h092
`define A_RSVD_93       10'h093
`define A_C5_DEC        10'h094
`define A_C5_SCALE      10'h095
`define A_RSVD_96       10'h096
`define A_RF_DEC        10'h0A0
`define A_RF_PHASE      10'h0A1
`define A_RF_TAPS       10'h0A2
`define A_RF_COFS       10'h0A3
`define A_RF_CTRL       10'h0A4
`define A_SIG_I         10'h0A5
`define A_SIG_Q         10'h0A6
`define A_ST_COUNT      10'h0A7
`define A_MEM_ST        10'h0A8
`define A_OUT_CTRL      10'h0A9
// Field positions.
`define SS_START        0
`define SS_HOP          1
`define PS_START_EN     0
`define PS_HOP_EN       1
`define PS_FIRST_ONLY   2
`define OC_BYPASS       0
`define OC_PH_DITHER    1
`define OC_AMP_DITHER   2
`define OC_CLR_HOP      3
`define OC_RSVD_LO      4
`define OC_RSVD_HI      5
`define OC_PORT_B       6
`define OC_SYNC_LO      7
`define OC_SYNC_HI      8
`define RC_COFS_BANK    8
`define RC_OTHER_SRC    9
`define RC_FMT_LO       4
`define RC_FMT_HI       5
`define MS_ENABLE       0
`define MS_COEFFICIENT_MEMORY_RESULT  1
`define MS_DMEM_RESULT  2
`define OUT_WIDE        5
`define OUT_MAP_SIG     9
// Widths and constants.
`define COEFFICIENT_MEMORY_W          20
`define COEFFICIENT_MEMORY_WORDS      256
`define HOLD_ONE        16'h0001
`define HOLD_ZERO       16'h0000
`endif

// ===== src/ddc_channel_oscillator_regs.v
`include "ddc_channel_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ddc_channel_oscillator_regs #(
  parameter ACC_W = 32,
  parameter SMP_W = 12
) (
  input  wire                 core_clk,
  input  wire                 arst_n,
  input  wire                 wr_en,
  input  wire                 rd_en,
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [19:0]          wdata,
  output reg  [19:0]          rdata,
  input  wire                 ext_sleep_wr,
  input  wire                 ext_sleep_bit,
  input  wire                 ext_pin_sync_wr,
  input  wire [2:0]           ext_pin_sync_bits,
  input  wire [3:0]           sync_pins,
  input  wire [SMP_W-1:0]     port_a_data,
  input  wire [SMP_W-1:0]     port_b_data,
  input  wire                 coefficient_memory_result,
  input  wire                 dmem_result,
  input  wire                 selftest_tick,
  output reg                  channel_sleep,
  output reg                  channel_start,
  output reg  [ACC_W-1:0]     freq_word,
  output reg  [ACC_W-1:0]     phase_acc,
  output reg  [15:0]          amplitude_phase,
  output reg  [SMP_W-1:0]     in_phase_data,
  output reg  [SMP_W-1:0]     quadrature_data,
  output reg                  amp_dither_en,
  output reg                  phase_dither_en,
  output reg  [1:0]           ram_filter_format,
  output reg                  ram_filter_other_src,
  output reg                  out_wide,
  output reg                  out_map_signature,
  output reg                  memory_selftest_en,
  output reg  [11:0]          resampler_decimation_m1,
  output reg  [8:0]           resampler_interpolation_m1,
  output reg  [7:0]           fifth_order_decimation_m1,
  output reg  [7:0]           ram_filter_decimation_m1,
  output reg  [7:0]           ram_filter_taps_m1
);

////////////////////////////////////////////////////////////////////////////////
  reg [`COEFFICIENT_MEMORY_W-1:0] coefficient_memory [0:`COEFFICIENT_MEMORY_WORDS-1];
  reg [1:0]  soft_sync_q;
  reg [2:0]  pin_sync_q;
  reg [15:0] start_hold_q;
  reg [15:0] freq_hold_q;
  reg [15:0] freq_lo_q;
  reg [15:0] freq_hi_q;
  reg [15:0] phase_ofs_q;
  reg [8:0]  osc_ctrl_q;
  reg [11:0] rs_scale_q;
  reg [4:0]  c5_scale_q;
  reg [7:0]  rf_phase_q;
  reg [7:0]  rf_cofs_q;
  reg [10:0] rf_ctrl_q;
  reg [15:0] sig_i_q;
  reg [15:0] sig_q_q;
  reg [19:0] st_count_q;
  reg [9:0]  out_ctrl_q;
  reg [15:0] start_cnt_q;
  reg [15:0] freq_cnt_q;
  reg        start_run_q;
  reg        freq_run_q;
  reg        pin_seen_q;

  wire       wr_hit_coefficient_memory = wr_en && (addr <= `A_COEFFICIENT_MEMORY_LAST);
  wire [7:0] coefficient_memory_index  = {rf_ctrl_q[`RC_COFS_BANK], addr[6:0]};

  // The pin chosen by the two select bits, gated by first-only.
  wire sync_sel   = sync_pins[osc_ctrl_q[`OC_SYNC_HI:`OC_SYNC_LO]];
  wire pin_ok     = sync_sel && !(pin_sync_q[`PS_FIRST_ONLY] && pin_seen_q);
  wire pin_start  = pin_ok && pin_sync_q[`PS_START_EN];
  wire pin_hop    = pin_ok && pin_sync_q[`PS_HOP_EN];
  wire soft_wr    = wr_en && (addr == `A_SOFT_SYNC);
  wire soft_start = soft_wr && wdata[`SS_START];
  wire soft_hop   = soft_wr && wdata[`SS_HOP];
  wire start_ev   = pin_start || soft_start;
  wire hop_ev     = pin_hop || soft_hop;

  // A hold-off of one fires in the trigger cycle; zero never arms.
  wire start_now  = start_ev && (start_hold_q == `HOLD_ONE);
  wire start_arm  = start_ev && (start_hold_q != `HOLD_ZERO) && (start_hold_q != `HOLD_ONE);
  wire start_done = start_run_q && (start_cnt_q == `HOLD_ONE);
  wire hop_now    = hop_ev && (freq_hold_q == `HOLD_ONE);
  wire hop_arm    = hop_ev && (freq_hold_q != `HOLD_ZERO) && (freq_hold_q != `HOLD_ONE);
  wire hop_done   = freq_run_q && (freq_cnt_q == `HOLD_ONE);
  wire hop_fire   = hop_now || hop_done;

  wire freq_shadow_wr = wr_en && ((addr == `A_FREQ_LO) || (addr == `A_FREQ_HI));
  wire immediate_upd  = freq_shadow_wr && (freq_hold_q == `HOLD_ONE);
  wire sleep_wr       = wr_en && (addr == `A_SLEEP);
  wire waking         = channel_sleep && ((sleep_wr && !wdata[0]) || start_now || start_done);

  // Shadow value as it will stand after this cycle's write, so a write and an
  // immediate copy in the same cycle take the new value.
  wire [15:0] lo_next = (wr_en && addr == `A_FREQ_LO) ? wdata[15:0] : freq_lo_q;
  wire [15:0] hi_next = (wr_en && addr == `A_FREQ_HI) ? wdata[15:0] : freq_hi_q;

////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (wr_hit_coefficient_memory) begin
      coefficient_memory[coefficient_memory_index] <= wdata;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_sync_q                <= 2'h0;
      pin_sync_q                 <= 3'h0;
      start_hold_q               <= 16'h0000;
      freq_hold_q                <= 16'h0000;
      freq_lo_q                  <= 16'h0000;
      freq_hi_q                  <= 16'h0000;
      phase_ofs_q                <= 16'h0000;
      osc_ctrl_q                 <= 9'h000;
      resampler_decimation_m1    <= 12'h000;
      resampler_interpolation_m1 <= 9'h000;
      rs_scale_q                 <= 12'h000;
      fifth_order_decimation_m1  <= 8'h00;
      c5_scale_q                 <= 5'h00;
      ram_filter_decimation_m1   <= 8'h00;
      rf_phase_q                 <= 8'h00;
      ram_filter_taps_m1         <= 8'h00;
      rf_cofs_q                  <= 8'h00;
      rf_ctrl_q                  <= 11'h000;
      sig_i_q                    <= 16'h0000;
      sig_q_q                    <= 16'h0000;
      out_ctrl_q                 <= 10'h000;
      memory_selftest_en         <= 1'b0;
    end else if (wr_en) begin
      case (addr)
        `A_SOFT_SYNC:  soft_sync_q <= wdata[1:0];
        `A_PIN_SYNC:   pin_sync_q <= wdata[2:0];
        `A_START_HOLD: start_hold_q <= wdata[15:0];
        `A_FREQ_HOLD:  freq_hold_q <= wdata[15:0];
        `A_FREQ_LO:    freq_lo_q <= wdata[15:0];
        `A_FREQ_HI:    freq_hi_q <= wdata[15:0];
        `A_PHASE_OFS:  phase_ofs_q <= wdata[15:0];
        // Reserved bits 5:4 are kept as written; software must write zero.
        `A_OSC_CTRL:   osc_ctrl_q <= wdata[8:0];
        `A_RS_DEC:     resampler_decimation_m1 <= wdata[11:0];
        `A_RS_INT:     resampler_interpolation_m1 <= wdata[8:0];
        `A_RS_SCALE:   rs_scale_q <= wdata[11:0];
        `A_C5_DEC:     fifth_order_decimation_m1 <= wdata[7:0];
        `A_C5_SCALE:   c5_scale_q <= wdata[4:0];
        `A_RF_DEC:     ram_filter_decimation_m1 <= wdata[7:0];
        `A_RF_PHASE:   rf_phase_q <= wdata[7:0];
        `A_RF_TAPS:    ram_filter_taps_m1 <= wdata[7:0];
        `A_RF_COFS:    rf_cofs_q <= wdata[7:0];
        `A_RF_CTRL:    rf_ctrl_q <= wdata[10:0];
        `A_SIG_I:      sig_i_q <= wdata[15:0];
        `A_SIG_Q:      sig_q_q <= wdata[15:0];
        `A_MEM_ST:     memory_selftest_en <= wdata[`MS_ENABLE];
        `A_OUT_CTRL:   out_ctrl_q <= wdata[9:0];
        default: begin
        end
      endcase
    end else if (ext_pin_sync_wr) begin
      pin_sync_q <= ext_pin_sync_bits;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // Sync hold-off counters, sleep and working frequency word.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_cnt_q   <= 16'h0000;
      freq_cnt_q    <= 16'h0000;
      start_run_q   <= 1'b0;
      freq_run_q    <= 1'b0;
      pin_seen_q    <= 1'b0;
      channel_sleep <= 1'b1;
      channel_start <= 1'b0;
      freq_word     <= {ACC_W{1'b0}};
      phase_acc     <= {ACC_W{1'b0}};
    end else begin
      // A pulse in the same cycle as the re-arm write wins, so the pin is left marked as seen.
      if (wr_en && addr == `A_PIN_SYNC) begin
        pin_seen_q <= 1'b0;
      end
      if (sync_sel) begin
        pin_seen_q <= 1'b1;
      end
      if (start_arm) begin
        start_cnt_q <= start_hold_q;
        start_run_q <= 1'b1;
      end else if (start_done) begin
        start_run_q <= 1'b0;
      end else if (start_run_q) begin
        start_cnt_q <= start_cnt_q - 16'h0001;
      end
      if (hop_arm) begin
        freq_cnt_q <= freq_hold_q;
        freq_run_q <= 1'b1;
      end else if (hop_done) begin
        freq_run_q <= 1'b0;
      end else if (freq_run_q) begin
        freq_cnt_q <= freq_cnt_q - 16'h0001;
      end
      channel_start <= start_now || start_done;
      if (start_now || start_done) begin
        channel_sleep <= 1'b0;
      end else if (sleep_wr) begin
        channel_sleep <= wdata[0];
      end else if (ext_sleep_wr) begin
        channel_sleep <= ext_sleep_bit;
      end
      if (hop_fire || immediate_upd || waking) begin
        freq_word <= {hi_next, lo_next};
      end
      if (hop_fire && osc_ctrl_q[`OC_CLR_HOP]) begin
        phase_acc <= {ACC_W{1'b0}};
      end else if (!channel_sleep) begin
        phase_acc <= phase_acc + freq_word;
      end
    end
  end

  // Self-test counter counts down on each selftest_tick until zero; reads show the live value.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_count_q <= 20'h00000;
    end else if (wr_en && addr == `A_ST_COUNT) begin
      st_count_q <= wdata;
    end else if (selftest_tick && st_count_q != 20'h00000) begin
      st_count_q <= st_count_q - 20'h00001;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      amplitude_phase      <= 16'h0000;
      in_phase_data        <= {SMP_W{1'b0}};
      quadrature_data      <= {SMP_W{1'b0}};
      amp_dither_en        <= 1'b0;
      phase_dither_en      <= 1'b0;
      ram_filter_format    <= 2'h0;
      ram_filter_other_src <= 1'b0;
      out_wide             <= 1'b0;
      out_map_signature    <= 1'b0;
    end else begin
      amplitude_phase <= phase_acc[ACC_W-1 -: 16] + phase_ofs_q;
      if (osc_ctrl_q[`OC_BYPASS]) begin
        in_phase_data   <= port_a_data;
        quadrature_data <= port_b_data;
      end else begin
        in_phase_data   <= osc_ctrl_q[`OC_PORT_B] ? port_b_data : port_a_data;
        quadrature_data <= {SMP_W{1'b0}};
      end
      amp_dither_en        <= osc_ctrl_q[`OC_AMP_DITHER];
      phase_dither_en      <= osc_ctrl_q[`OC_PH_DITHER];
      ram_filter_format    <= rf_ctrl_q[`RC_FMT_HI:`RC_FMT_LO];
      ram_filter_other_src <= rf_ctrl_q[`RC_OTHER_SRC];
      out_wide             <= out_ctrl_q[`OUT_WIDE];
      out_map_signature    <= out_ctrl_q[`OUT_MAP_SIG];
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // Read data is registered; unmapped addresses return zero.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 20'h00000;
    end else if (rd_en) begin
      if (addr <= `A_COEFFICIENT_MEMORY_LAST) begin
        rdata <= coefficient_memory[coefficient_memory_index];
      end else begin
        case (addr)
          `A_SLEEP:      rdata <= {19'h00000, channel_sleep};
          `A_SOFT_SYNC:  rdata <= {18'h00000, soft_sync_q};
          `A_PIN_SYNC:   rdata <= {17'h00000, pin_sync_q};
          `A_START_HOLD: rdata <= {4'h0, start_hold_q};
          `A_FREQ_HOLD:  rdata <= {4'h0, freq_hold_q};
          `A_FREQ_LO:    rdata <= {4'h0, freq_lo_q};
          `A_FREQ_HI:    rdata <= {4'h0, freq_hi_q};
          `A_PHASE_OFS:  rdata <= {4'h0, phase_ofs_q};
          `A_OSC_CTRL:   rdata <= {11'h000, osc_ctrl_q};
          `A_RS_DEC:     rdata <= {8'h00, resampler_decimation_m1};
          `A_RS_INT:     rdata <= {11'h000, resampler_interpolation_m1};
          `A_RS_SCALE:   rdata <= {8'h00, rs_scale_q};
          `A_C5_DEC:     rdata <= {12'h000, fifth_order_decimation_m1};
          `A_C5_SCALE:   rdata <= {15'h0000, c5_scale_q};
          `A_RF_DEC:     rdata <= {12'h000, ram_filter_decimation_m1};
          `A_RF_PHASE:   rdata <= {12'h000, rf_phase_q};
          `A_RF_TAPS:    rdata <= {12'h000, ram_filter_taps_m1};
          `A_RF_COFS:    rdata <= {12'h000, rf_cofs_q};
          `A_RF_CTRL:    rdata <= {9'h000, rf_ctrl_q};
          `A_SIG_I:      rdata <= {4'h0, sig_i_q};
          `A_SIG_Q:      rdata <= {4'h0, sig_q_q};
          `A_ST_COUNT:   rdata <= st_count_q;
          `A_MEM_ST:     rdata <= {17'h00000, dmem_result, coefficient_memory_result, memory_selftest_en};
          `A_OUT_CTRL:   rdata <= {10'h000, out_ctrl_q};
          default:       rdata <= 20'h00000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== tb/ddc_osc_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ddc_osc_regs_properties #(
  parameter ACC_W = 32,
  parameter SMP_W = 12
) (
  input wire logic             core_clk,
  input wire logic             arst_n,
  input wire logic             wr_en,
  input wire logic             rd_en,
  input wire logic [9:0]       addr,
  input wire logic [19:0]      wdata,
  input wire logic [19:0]      rdata,
  input wire logic             ext_sleep_wr,
  input wire logic [SMP_W-1:0] port_a_data,
  input wire logic [SMP_W-1:0] port_b_data,
  input wire logic             channel_sleep,
  input wire logic [ACC_W-1:0] freq_word,
  input wire logic [ACC_W-1:0] phase_acc,
  input wire logic [15:0]      amplitude_phase,
  input wire logic [SMP_W-1:0] in_phase_data,
  input wire logic [SMP_W-1:0] quadrature_data,
  input wire logic             amp_dither_en,
  input wire logic             phase_dither_en,
  input wire logic [11:0]      resampler_decimation_m1
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [15:0] ofs_q, hold_q, lo_q, hi_q;
  logic [8:0]  oc_q;
  // Shadow copies of the registers that the relations below depend on.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ofs_q <= 16'h0000; hold_q <= 16'h0000; lo_q <= 16'h0000; hi_q <= 16'h0000; oc_q <= 9'h000;
    end else if (wr_en) begin
      if (addr == 10'h087) ofs_q <= wdata[15:0];
      if (addr == 10'h084) hold_q <= wdata[15:0];
      if (addr == 10'h085) lo_q <= wdata[15:0];
      if (addr == 10'h086) hi_q <= wdata[15:0];
      if (addr == 10'h088) oc_q <= wdata[8:0];
    end
  end
  sequence soft_hop_s;
    wr_en && addr == 10'h081 && wdata[1] && hold_q == 16'h0001 && oc_q[3];
  endsequence
  sequence hop_done_s;
    freq_word == ACC_W'({hi_q, lo_q}) && (phase_acc == '0 || phase_acc == freq_word);
  endsequence
  rd_unused_zero_a: assert property (rd_en && (addr inside {[10'h089:10'h08F], [10'h097:10'h09F]} || addr > 10'h0A9)
    |=> rdata == 20'h00000) else $error("unused address read not zero");
  rd_data_stands_a: assert property (!rd_en |=> $stable(rdata)) else $error("read data moved without a read");
  amp_phase_sum_a: assert property (amplitude_phase == $past(phase_acc[ACC_W-1 -: 16]) + $past(ofs_q))
    else $error("amplitude phase is not accumulator plus offset");
  dither_bits_a: assert property ({amp_dither_en, phase_dither_en} == $past(oc_q[2:1])) else $error("dither enables wrong");
  bypass_route_a: assert property (oc_q[0] && $past(oc_q[0]) && $stable(port_a_data) && $stable(port_b_data)
    |-> in_phase_data == port_a_data && quadrature_data == port_b_data) else $error("bypass routing wrong");
  dec_minus_one_a: assert property (wr_en && addr == 10'h090 |=> resampler_decimation_m1 == $past(wdata[11:0]))
    else $error("decimation count not stored");
  hold_one_copy_a: assert property (wr_en && addr == 10'h086 && hold_q == 16'h0001
    |=> freq_word[31:16] == $past(wdata[15:0])) else $error("shadow not copied with hold-off one");
  shadow_hold_a: assert property (wr_en && addr == 10'h086 && hold_q == 16'h0000 && !channel_sleep && !ext_sleep_wr
    |=> $stable(freq_word)) else $error("working frequency changed on shadow write");
  hop_clear_a: assert property (soft_hop_s |-> ##[1:3] hop_done_s) else $error("hop did not load and clear");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ddc_channel_oscillator_regs ddc_osc_regs_properties #(.ACC_W(ACC_W), .SMP_W(SMP_W)) i_chk (
  .core_clk(core_clk), .arst_n(arst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
  .rdata(rdata), .ext_sleep_wr(ext_sleep_wr), .port_a_data(port_a_data), .port_b_data(port_b_data),
  .channel_sleep(channel_sleep), .freq_word(freq_word), .phase_acc(phase_acc),
  .amplitude_phase(amplitude_phase), .in_phase_data(in_phase_data), .quadrature_data(quadrature_data),
  .amp_dither_en(amp_dither_en), .phase_dither_en(phase_dither_en),
  .resampler_decimation_m1(resampler_decimation_m1));
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rd_pend = 1'b0;
  logic        ext_sleep_wr = 1'b0, ext_sleep_bit = 1'b0, selftest_tick = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic [19:0] wdata = 20'h00000, rdata, v [13];
  logic [3:0]  sync_pins = 4'h0;
  logic [1:0]  mem_res = 2'h0, rf_fmt;
  logic        rf_src, o_wide, o_map;
  logic [11:0] port_a_data = 12'h000, port_b_data = 12'h000, in_phase_data, quadrature_data, rs_dec;
  logic        channel_sleep, channel_start;
  logic [31:0] freq_word, f, e;
  logic [19:0] exp_q [$];
  int          fail_count = 0, num_checks = 0, starts = 0, k, n;
  localparam logic [9:0]  RA [13] = '{10'h082, 10'h083, 10'h087, 10'h090, 10'h091, 10'h092, 10'h094,
                                      10'h095, 10'h0A0, 10'h0A1, 10'h0A2, 10'h0A3, 10'h0A9};
  localparam logic [19:0] RM [13] = '{20'h7, 20'hFFFF, 20'hFFFF, 20'hFFF, 20'h1FF, 20'h3FF, 20'hFF,
                                      20'h1F, 20'hFF, 20'hFF, 20'hFF, 20'hFF, 20'h3E0};
  always #25 core_clk = ~core_clk;
  ddc_channel_oscillator_regs i_dut (.core_clk(core_clk), .arst_n(arst_n), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .ext_sleep_wr(ext_sleep_wr), .ext_sleep_bit(ext_sleep_bit),
    .ext_pin_sync_wr(1'b0), .ext_pin_sync_bits(3'h0), .sync_pins(sync_pins), .port_a_data(port_a_data),
    .port_b_data(port_b_data), .coefficient_memory_result(mem_res[0]), .dmem_result(mem_res[1]), .selftest_tick(selftest_tick),
    .channel_sleep(channel_sleep), .channel_start(channel_start), .freq_word(freq_word), .phase_acc(),
    .amplitude_phase(), .in_phase_data(in_phase_data), .quadrature_data(quadrature_data),
    .amp_dither_en(), .phase_dither_en(), .ram_filter_format(rf_fmt), .ram_filter_other_src(rf_src),
    .out_wide(o_wide), .out_map_signature(o_map), .memory_selftest_en(), .resampler_decimation_m1(rs_dec),
    .resampler_interpolation_m1(), .fifth_order_decimation_m1(), .ram_filter_decimation_m1(),
    .ram_filter_taps_m1());
////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [19:0] d);
    @(negedge core_clk);
    wr_en = 1'b1; addr = a; wdata = d;
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [19:0] d);
    @(negedge core_clk);
    rd_en = 1'b1; addr = a; exp_q.push_back(d);
    @(negedge core_clk);
    rd_en = 1'b0;
  endtask
  // One-cycle pin pulse, then settle time so a start can show before the next step.
  task automatic pulse(input int p);
    @(negedge core_clk) sync_pins = 4'h1 << p;
    @(negedge core_clk) sync_pins = 4'h0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (rd_pend) chk(rdata, exp_q.pop_front());
    rd_pend <= rd_en;
    if (channel_start) starts <= starts + 1;
  end
  initial begin
    #200us;
    fail_count++;
    end_of_test;
  end
////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(49));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1'b1;
    chk(channel_sleep, 1);
    foreach (RA[i]) begin
      v[i] = $urandom & RM[i];
      wr(RA[i], v[i]);
    end
    foreach (RA[i]) rd(RA[i], v[i]);
    chk(rs_dec, v[3]);
    foreach (RA[i]) if (i < 4) wr(i[1:0] == 0 ? 10'h089 : i[1:0] == 1 ? 10'h097 : i[1:0] == 2 ? 10'h0AA : 10'h3FF, $urandom);
    foreach (RA[i]) if (i < 4) rd(i[1:0] == 0 ? 10'h089 : i[1:0] == 1 ? 10'h097 : i[1:0] == 2 ? 10'h0AA : 10'h3FF, 0);
    f = $urandom;
    wr(10'h0A4, 20'h0); wr(10'h07F, f[19:0]); wr(10'h0A4, 20'h100); wr(10'h07F, ~f[19:0]);
    rd(10'h07F, ~f[19:0]); rd(10'h0A4, 20'h100); wr(10'h0A4, 20'h0); rd(10'h07F, f[19:0]);
    wr(10'h0A7, 20'h5);
    repeat (2) begin
      @(negedge core_clk) selftest_tick = 1'b1;
      @(negedge core_clk) selftest_tick = 1'b0;
    end
    rd(10'h0A7, 20'h3);
    chk({o_map, o_wide}, {v[12][9], v[12][5]});
    wr(10'h0A4, 20'h230);
    @(negedge core_clk) mem_res = $urandom;
    chk(rf_fmt, 2'h3);
    chk(rf_src, 1'b1);
    wr(10'h0A8, 20'h1);
    rd(10'h0A8, {17'h00000, mem_res, 1'b1});
    wr(10'h080, 20'h0);
    chk(channel_sleep, 0);
    @(negedge core_clk) begin ext_sleep_wr = 1'b1; ext_sleep_bit = 1'b1; end
    @(negedge core_clk) ext_sleep_wr = 1'b0;
    rd(10'h080, 20'h1);
    wr(10'h080, 20'h0);
    // Hold-off zero: shadow writes alone must leave the working word alone.
    wr(10'h084, 20'h0); wr(10'h088, 20'h008); f = {$urandom, $urandom};
    wr(10'h085, f[15:0]); wr(10'h086, f[31:16]);
    chk(freq_word, 0);
    wr(10'h084, 20'h3); wr(10'h081, 20'h2);
    chk(freq_word, 0);
    n = 0;
    while (freq_word !== f && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    chk(freq_word, f);
    wr(10'h084, 20'h1); e = $urandom; wr(10'h086, e[15:0]);
    chk(freq_word[31:16], e[15:0]);
    wr(10'h081, 20'h2);
    foreach (RA[i]) if (i < 3) begin
      e = i == 0 ? 32'h7 : i == 1 ? 32'h42 : 32'h4;
      wr(10'h088, e[19:0]);
      @(negedge core_clk) begin port_a_data = $urandom; port_b_data = $urandom; end
      repeat (2) @(negedge core_clk);
      chk(in_phase_data, e[0] ? port_a_data : e[6] ? port_b_data : port_a_data);
      chk(quadrature_data, e[0] ? port_b_data : 12'h000);
    end
    wr(10'h083, 20'h1); wr(10'h082, 20'h1);
    for (int s = 0; s < 4; s++) begin
      wr(10'h080, 20'h1); wr(10'h088, 20'(s << 7)); k = starts;
      pulse((s + 1) % 4); pulse(s);
      chk(starts - k, 1);
      chk(channel_sleep, 0);
    end
    wr(10'h083, 20'h0); k = starts; pulse(3);
    chk(starts - k, 0);
    k = starts; wr(10'h083, 20'h1); wr(10'h082, 20'h5); pulse(3); pulse(3);
    chk(starts - k, 1);
    repeat (3) @(negedge core_clk);
    end_of_test;
  end
endmodule
`default_nettype wire
